//--- ceau_addr_calc.sv
module ceau_addr_calc
   import ceau_pkg::*;
(
   input  wire logic [15:0] base,
   input  wire logic [7:0]  index,
   input  wire logic        add_index,
   input  wire logic        is_rel,
   input  wire logic [15:0] pc,
   output      logic [15:0] sum
);
   import ceau_pkg::*;

   // Unsigned index add, or signed PC displacement for relative forms
   wire logic [15:0] idx_sum = base + {8'h00, (add_index ? index : 8'h00)};
   wire logic [15:0] rel_sum = pc + {{8{base[7]}}, base[7:0]};

   assign sum = is_rel ? rel_sum : idx_sum;
endmodule // ceau_addr_calc

//--- ceau_core.sv
// Behaviour
// - Inherent instructions: opcode only, no operand fetch.
// - Immediate: next byte is operand value.
// - Short direct: one address byte, page zero.
// - Long direct: two address bytes, full space.
// - Indexed address is unsigned index plus offset.
// - No-offset indexed: address equals index register.
// - Short indexed: byte offset plus index, to 1FE.
// - Long indexed: word offset plus index.
// - Short indirect: byte pointer read from page zero.
// - Long indirect: word pointer read from page zero.
// - Indirect indexed: pointer read, then index added.
// - Short indirect indexed: byte pointer, reach 1FE.
// - Short direct forms page zero, long forms full space.
// - Read-modify-write instructions only short variants.
// - Set-mask instruction raises mask to level 3.
// - Clear-mask instruction lowers mask to level 0.
// - Halt stops oscillator; wait enters low-power wait.
// - Relative adds signed 8-bit offset to PC.
// - Prefix 90 selects second index register.
// - Prefix 92 converts direct/offset indexed forms to indirect.
// - Prefix 91 indirect indexed with second index.
module ceau_core
   import ceau_pkg::*;
(
   input  wire logic                 CLK,
   input  wire logic                 NRST,
   input  wire logic                 CE,
   input  wire logic                 START,
   input  wire logic [15:0]          PC_IN,
   input  wire logic [7:0]           INDEX_X,
   input  wire logic [7:0]           INDEX_Y,
   input  wire ceau_pkg::ceau_class_s OPC_CLASS,
   output      logic [7:0]           OPCODE,
   output      logic                 OPCODE_VALID,
   output      ceau_pkg::ceau_mem_req_s MEM_REQ,
   input  wire logic                 MEM_ACK,
   input  wire logic [7:0]           MEM_RDATA,
   output      ceau_pkg::ceau_result_s RESULT,
   output      logic                 DONE,
   output      logic                 BUSY,
   output      logic [1:0]           IRQ_MASK,
   output      logic                 HALT_REQ,
   output      logic                 WAIT_REQ
);
   import ceau_pkg::*;

   typedef enum logic [7:0] {
      S_IDLE   = 8'b0000_0001,
      S_OPC    = 8'b0000_0010,
      S_ARG_HI = 8'b0000_0100,
      S_ARG_LO = 8'b0000_1000,
      S_PTR_HI = 8'b0001_0000,
      S_PTR_LO = 8'b0010_0000,
      S_CALC   = 8'b0100_0000,
      S_DONE   = 8'b1000_0000
   } ceau_state_e;

   ceau_state_e  state_r, state_nxt;
   logic [15:0]  pc_r;
   logic [7:0]   opc_r;
   logic [1:0]   pfx_r;        // 0 none, 1 second idx, 2 indirect, 3 indirect second
   logic [7:0]   hi_r;
   logic [15:0]  val_r;        // Address, offset or pointer as gathered
   logic [7:0]   ptr_addr_r;
   logic         word_r;
   logic [1:0]   irq_mask_r;
   logic         halt_r;
   logic         wait_r;
   ceau_result_s res_r;
   logic         done_r;

   function automatic logic is_prefix(input logic [7:0] b);
      is_prefix = (b == PREFIX_USE_SECOND_INDEX) ||
                  (b == PREFIX_INDIRECT_SECOND_INDEX) ||
                  (b == PREFIX_MAKE_INDIRECT);
   endfunction

   // Operand byte count following opcode before any pointer read
   function automatic logic [1:0] arg_bytes(input ceau_mode_e m, input logic ind);
      case (m)
         CEAU_AM_INHERENT:    arg_bytes = 2'd0;
         CEAU_AM_IMMEDIATE:   arg_bytes = 2'd1;
         CEAU_AM_DIR_SHORT:   arg_bytes = 2'd1;
         CEAU_AM_DIR_LONG:    arg_bytes = ind ? 2'd1 : 2'd2;
         CEAU_AM_IDX_NOOFS:   arg_bytes = 2'd0;
         CEAU_AM_IDX_SHORT:   arg_bytes = 2'd1;
         CEAU_AM_IDX_LONG:    arg_bytes = ind ? 2'd1 : 2'd2;
         CEAU_AM_REL_DIRECT:  arg_bytes = 2'd1;
         CEAU_AM_BIT_DIRECT:  arg_bytes = 2'd1;
         CEAU_AM_BIT_DIR_REL: arg_bytes = 2'd1;
         default:             arg_bytes = 2'd0;
      endcase
   endfunction

   wire ceau_class_s cls       = OPC_CLASS;
   wire logic        pfx_ind   = pfx_r[1];
   // Prefix 92 only converts direct, bit, relative and offset indexed forms
   wire logic        ind_ok    = (cls.mode != CEAU_AM_INHERENT) &&
                                 (cls.mode != CEAU_AM_IMMEDIATE) &&
                                 (cls.mode != CEAU_AM_IDX_NOOFS);
   wire logic        indirect  = pfx_ind && ind_ok;
   // Long direct/indexed with 92 become word pointer (long indirect forms)
   wire logic        long_form = (cls.mode == CEAU_AM_DIR_LONG) ||
                                 (cls.mode == CEAU_AM_IDX_LONG);
   // Second index: 90 on non-indirect forms, 91 on indirect indexed
   wire logic        second_ix = (pfx_r == 2'd1 && !indirect) ||
                                 (pfx_r == 2'd3 && indirect && cls.uses_index);
   wire logic        bad_pfx   = (pfx_r == 2'd3 && !(indirect && cls.uses_index)) ||
                                 (pfx_r == 2'd2 && !ind_ok);
   // Long forms not allowed on read-modify-write
   wire logic        bad_rmw   = cls.rmw && long_form;
   wire logic [1:0]  nargs     = arg_bytes(cls.mode, indirect);
   wire logic [7:0]  idx_val   = second_ix ? INDEX_Y : INDEX_X;
   wire logic        is_rel    = (cls.mode == CEAU_AM_REL_DIRECT) ||
                                 (cls.mode == CEAU_AM_BIT_DIR_REL);
   wire logic        mem_rd_now = (state_r == S_OPC) || (state_r == S_ARG_HI) ||
                                 (state_r == S_ARG_LO) || (state_r == S_PTR_HI) ||
                                 (state_r == S_PTR_LO);
   wire logic        ptr_phase = (state_r == S_PTR_HI) || (state_r == S_PTR_LO);
   wire logic        take      = MEM_ACK && CE;
   wire logic [15:0] calc_sum;

   // Address base: offset/address or pointer; no-offset uses zero
   wire logic [15:0] calc_base = (cls.mode == CEAU_AM_IDX_NOOFS) ? 16'h0000 : val_r;
   wire logic        add_ix    = cls.uses_index;

   ceau_addr_calc u_calc (
      .base      (calc_base),
      .index     (idx_val),
      .add_index (add_ix),
      .is_rel    (is_rel && !cls.uses_index),
      .pc        (pc_r),
      .sum       (calc_sum)
   );

   // Argument plan is settled once the class for the opcode is known
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:   if (START) state_nxt = S_OPC;
         S_OPC:    if (take && !is_prefix(MEM_RDATA)) state_nxt = S_ARG_HI;
         S_ARG_HI: if (nargs == 2'd0)
                      state_nxt = S_CALC;
                   else if (take && nargs == 2'd2)
                      state_nxt = S_ARG_LO;
                   else if (take && indirect)
                      state_nxt = long_form ? S_PTR_HI : S_PTR_LO;
                   else if (take)
                      state_nxt = S_CALC;
         S_ARG_LO: if (take) state_nxt = S_CALC;
         S_PTR_HI: if (take) state_nxt = S_PTR_LO;
         S_PTR_LO: if (take) state_nxt = S_CALC;
         S_CALC:   state_nxt = S_DONE;
         S_DONE:   state_nxt = S_IDLE;
         default:  state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_r    <= S_IDLE;
         pc_r       <= 16'h0000;
         opc_r      <= 8'h00;
         pfx_r      <= 2'd0;
         hi_r       <= 8'h00;
         val_r      <= 16'h0000;
         ptr_addr_r <= 8'h00;
         word_r     <= 1'b0;
      end else if (CE) begin
         state_r <= state_nxt;
         case (state_r)
            S_IDLE: if (START) begin
               pc_r  <= PC_IN;
               pfx_r <= 2'd0;
               val_r <= 16'h0000;
            end
            S_OPC: if (MEM_ACK) begin
               pc_r <= pc_r + 16'h0001;
               if (MEM_RDATA == PREFIX_USE_SECOND_INDEX)
                  pfx_r <= 2'd1;
               else if (MEM_RDATA == PREFIX_MAKE_INDIRECT)
                  pfx_r <= 2'd2;
               else if (MEM_RDATA == PREFIX_INDIRECT_SECOND_INDEX)
                  pfx_r <= 2'd3;
               else
                  opc_r <= MEM_RDATA;
            end
            S_ARG_HI: if (nargs != 2'd0 && MEM_ACK) begin
               pc_r <= pc_r + 16'h0001;
               if (nargs == 2'd2)
                  hi_r <= MEM_RDATA;
               else begin
                  // Pointer fields only matter when the form is indirect
                  val_r      <= {8'h00, MEM_RDATA};
                  ptr_addr_r <= MEM_RDATA;
                  word_r     <= long_form;
               end
            end
            S_ARG_LO: if (MEM_ACK) begin
               pc_r  <= pc_r + 16'h0001;
               val_r <= {hi_r, MEM_RDATA};
            end
            S_PTR_HI: if (MEM_ACK) begin
               hi_r       <= MEM_RDATA;
               ptr_addr_r <= ptr_addr_r + 8'h01;
            end
            S_PTR_LO: if (MEM_ACK)
               val_r <= word_r ? {hi_r, MEM_RDATA} : {8'h00, MEM_RDATA};
            default: ;
         endcase
      end
   end

   // Result capture in S_CALC
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         res_r  <= '0;
         done_r <= 1'b0;
      end else if (CE) begin
         done_r <= (state_r == S_CALC);
         if (state_r == S_CALC) begin
            res_r.is_immediate <= (cls.mode == CEAU_AM_IMMEDIATE) && !indirect;
            res_r.operand      <= val_r[7:0];
            res_r.has_ea       <= (cls.mode != CEAU_AM_INHERENT) &&
                                  (cls.mode != CEAU_AM_IMMEDIATE) && !is_rel;
            res_r.is_relative  <= is_rel;
            res_r.ea           <= calc_sum;
            res_r.second_index <= second_ix;
            res_r.indirect     <= indirect;
            res_r.illegal      <= bad_pfx || bad_rmw;
            res_r.next_pc      <= pc_r;
         end
      end
   end

   // Interrupt mask and low-power requests from inherent opcodes
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         irq_mask_r <= IRQ_MASK_RESET_VALUE;
         halt_r     <= 1'b0;
         wait_r     <= 1'b0;
      end else if (CE) begin
         halt_r <= 1'b0;
         wait_r <= 1'b0;
         if (state_r == S_CALC && cls.mode == CEAU_AM_INHERENT) begin
            case (cls.op)
               CEAU_OP_SET_MASK: irq_mask_r <= IRQ_MASK_SET_LEVEL;
               CEAU_OP_CLR_MASK: irq_mask_r <= IRQ_MASK_CLEAR_LEVEL;
               CEAU_OP_HALT:     halt_r     <= 1'b1;
               CEAU_OP_WAIT:     wait_r     <= 1'b1;
               default:          ;
            endcase
         end
      end
   end

   // Pointer reads come from page zero, stream reads from PC
   assign MEM_REQ.rd   = mem_rd_now && !(state_r == S_ARG_HI && nargs == 2'd0);
   assign MEM_REQ.code = !ptr_phase;
   assign MEM_REQ.addr = ptr_phase ? {8'h00, ptr_addr_r} : pc_r;
   assign OPCODE       = opc_r;
   assign OPCODE_VALID = (state_r != S_IDLE) && (state_r != S_OPC);
   assign RESULT       = res_r;
   assign DONE         = done_r;
   assign BUSY         = (state_r != S_IDLE);
   assign IRQ_MASK     = irq_mask_r;
   assign HALT_REQ     = halt_r;
   assign WAIT_REQ     = wait_r;
endmodule // ceau_core

//--- ceau_core_asserts.sv
module ceau_core_asserts
   import ceau_pkg::*;
(
   input wire logic                    CLK,
   input wire logic                    NRST,
   input wire logic                    CE,
   input wire logic                    START,
   input wire logic [15:0]             PC_IN,
   input wire logic [7:0]              INDEX_X,
   input wire logic [7:0]              INDEX_Y,
   input wire ceau_pkg::ceau_class_s   OPC_CLASS,
   input wire ceau_pkg::ceau_mem_req_s MEM_REQ,
   input wire logic                    MEM_ACK,
   input wire ceau_pkg::ceau_result_s  RESULT,
   input wire logic                    DONE,
   input wire logic                    BUSY,
   input wire logic [1:0]              IRQ_MASK,
   input wire logic                    HALT_REQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   start_fetch_a: assert property (START && !BUSY && CE |=>
      MEM_REQ.rd && MEM_REQ.code && MEM_REQ.addr == $past(PC_IN))
      else $error("opcode fetch not at start address");
   req_hold_a: assert property (MEM_REQ.rd && !MEM_ACK && CE |=>
      MEM_REQ.rd && $stable(MEM_REQ.addr)) else $error("read request dropped");
   done_pulse_a: assert property (DONE && CE |=> !DONE) else $error("done too long");
   inh_len_a: assert property (DONE && OPC_CLASS.mode == CEAU_AM_INHERENT
      && !RESULT.second_index |-> RESULT.next_pc == PC_IN + 16'h0001)
      else $error("inherent length wrong");
   imm_no_ea_a: assert property (DONE && RESULT.is_immediate |-> !RESULT.has_ea)
      else $error("immediate used as address");
   dir_page_a: assert property (DONE && OPC_CLASS.mode == CEAU_AM_DIR_SHORT
      && !RESULT.indirect |-> RESULT.ea <= PAGE_ZERO_TOP) else $error("short direct off page");
   idx_noofs_a: assert property (DONE && OPC_CLASS.mode == CEAU_AM_IDX_NOOFS
      && !RESULT.indirect |-> RESULT.ea == {8'h00, RESULT.second_index ? INDEX_Y : INDEX_X})
      else $error("no-offset address wrong");
   idx_reach_a: assert property (DONE && OPC_CLASS.mode == CEAU_AM_IDX_SHORT
      && !RESULT.indirect |-> RESULT.ea <= 16'h01fe) else $error("short index reach");
   ptr_page_a: assert property (MEM_REQ.rd && !MEM_REQ.code |-> MEM_REQ.addr[15:8] == 8'h00)
      else $error("pointer read off page zero");
   mask_set_a: assert property (DONE && OPC_CLASS.op == CEAU_OP_SET_MASK
      |-> ##[0:2] IRQ_MASK == IRQ_MASK_SET_LEVEL) else $error("mask not raised");
   halt_src_a: assert property (HALT_REQ |-> OPC_CLASS.op == CEAU_OP_HALT ##1 !HALT_REQ)
      else $error("stray halt request");
endmodule // ceau_core_asserts

bind ceau_core ceau_core_asserts chk_u (.CLK(CLK), .NRST(NRST), .CE(CE), .START(START),
   .PC_IN(PC_IN), .INDEX_X(INDEX_X), .INDEX_Y(INDEX_Y), .OPC_CLASS(OPC_CLASS),
   .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK), .RESULT(RESULT), .DONE(DONE), .BUSY(BUSY),
   .IRQ_MASK(IRQ_MASK), .HALT_REQ(HALT_REQ));

//--- ceau_mem_model.sv
module ceau_mem_model
   import ceau_pkg::*;
(
   input  wire logic                    CLK,
   input  wire logic                    NRST,
   input  wire logic [1:0]              LAT,
   input  wire ceau_pkg::ceau_mem_req_s MEM_REQ,
   output      logic                    MEM_ACK,
   output      logic [7:0]              MEM_RDATA
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [1:0] wait_r;

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         MEM_ACK <= 1'b0;
         MEM_RDATA <= 8'h00;
         wait_r <= 2'h0;
      end else if (MEM_REQ.rd && !MEM_ACK && wait_r >= LAT) begin
         MEM_ACK <= 1'b1;
         MEM_RDATA <= mem[MEM_REQ.addr];
         wait_r <= 2'h0;
      end else begin
         // Stale data inverted so a sample one cycle late does not match
         MEM_ACK <= 1'b0;
         MEM_RDATA <= ~MEM_RDATA;
         wait_r <= (MEM_REQ.rd && !MEM_ACK) ? wait_r + 2'h1 : 2'h0;
      end
   end
endmodule // ceau_mem_model

//--- ceau_pkg.sv
package ceau_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // Prefix byte values
   localparam logic [7:0] PREFIX_USE_SECOND_INDEX     = 8'h90;
   localparam logic [7:0] PREFIX_INDIRECT_SECOND_INDEX = 8'h91;
   localparam logic [7:0] PREFIX_MAKE_INDIRECT        = 8'h92;

   // Interrupt mask levels
   localparam logic [1:0] IRQ_MASK_SET_LEVEL   = 2'h3;
   localparam logic [1:0] IRQ_MASK_CLEAR_LEVEL = 2'h0;
   localparam logic [1:0] IRQ_MASK_RESET_VALUE = 2'h3;

   // Page zero limit
   localparam logic [15:0] PAGE_ZERO_TOP = 16'h00ff;

   // Addressing modes presented by the opcode decoder
   typedef enum logic [3:0] {
      CEAU_AM_INHERENT    = 4'h0,
      CEAU_AM_IMMEDIATE   = 4'h1,
      CEAU_AM_DIR_SHORT   = 4'h2,
      CEAU_AM_DIR_LONG    = 4'h3,
      CEAU_AM_IDX_NOOFS   = 4'h4,
      CEAU_AM_IDX_SHORT   = 4'h5,
      CEAU_AM_IDX_LONG    = 4'h6,
      CEAU_AM_REL_DIRECT  = 4'h7,
      CEAU_AM_BIT_DIRECT  = 4'h8,
      CEAU_AM_BIT_DIR_REL = 4'h9
   } ceau_mode_e;

   // Inherent special operations
   typedef enum logic [2:0] {
      CEAU_OP_NONE     = 3'h0,
      CEAU_OP_SET_MASK = 3'h1,
      CEAU_OP_CLR_MASK = 3'h2,
      CEAU_OP_HALT     = 3'h3,
      CEAU_OP_WAIT     = 3'h4
   } ceau_op_e;

   // Instruction class from the opcode decoder
   typedef struct packed {
      ceau_mode_e mode;
      logic       uses_index;
      logic       rmw;
      ceau_op_e   op;
   } ceau_class_s;

   // Memory request to the core bus
   typedef struct packed {
      logic        rd;
      logic        code;
      logic [15:0] addr;
   } ceau_mem_req_s;

   // Final decode result
   typedef struct packed {
      logic        is_immediate;
      logic        has_ea;
      logic        is_relative;
      logic        second_index;
      logic        indirect;
      logic        illegal;
      logic [7:0]  operand;
      logic [15:0] ea;
      logic [15:0] next_pc;
   } ceau_result_s;

endpackage

//--- cpu_effective_address_unit_tb.sv
module cpu_effective_address_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ceau_pkg::*;
   logic          CLK = 1'b0, NRST = 1'b0, START = 1'b0, rmw_v = 1'b0, CE = 1'b1;
   logic [15:0]   PC_IN = 16'h0000;
   logic [7:0]    INDEX_X = 8'hf0, INDEX_Y = 8'hff, OPCODE, MEM_RDATA;
   logic [1:0]    IRQ_MASK, LAT = 2'h0;
   logic          OPCODE_VALID, MEM_ACK, DONE, BUSY, HALT_REQ, WAIT_REQ;
   ceau_class_s   OPC_CLASS = '0;
   ceau_mem_req_s MEM_REQ;
   ceau_result_s  RESULT;
   int            error_cnt = 0, num_checks = 0, halt_cnt = 0, wait_cnt = 0;

   ceau_core dut_u (.CLK(CLK), .NRST(NRST), .CE(CE), .START(START), .PC_IN(PC_IN),
      .INDEX_X(INDEX_X), .INDEX_Y(INDEX_Y), .OPC_CLASS(OPC_CLASS), .OPCODE(OPCODE),
      .OPCODE_VALID(OPCODE_VALID), .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK),
      .MEM_RDATA(MEM_RDATA), .RESULT(RESULT), .DONE(DONE), .BUSY(BUSY),
      .IRQ_MASK(IRQ_MASK), .HALT_REQ(HALT_REQ), .WAIT_REQ(WAIT_REQ));
   ceau_mem_model mem_u (.CLK(CLK), .NRST(NRST), .LAT(LAT), .MEM_REQ(MEM_REQ),
      .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));

   always #50 CLK = ~CLK;
   // Pulses counted mid-cycle, away from the edge that launches them
   always @(negedge CLK) begin
      halt_cnt += (HALT_REQ === 1'b1);
      wait_cnt += (WAIT_REQ === 1'b1);
   end

   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task bail(input string nm);
      $display("wrong value %s expected event seen timeout", nm);
      error_cnt++;
      stop_test;
   endtask

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask

   // Bytes of code go MSB first from pc; START held until the core turns busy
   task go(input logic [15:0] pc, input ceau_mode_e m, input ceau_op_e op,
           input logic [31:0] code, input int n);
      int i;
      for (i = 0; i < n; i++)
         mem_u.mem[pc + 16'(i)] = code[8*(n-1-i) +: 8];
      for (i = 0; i < 50 && BUSY !== 1'b0; i++)
         @(negedge CLK);
      if (BUSY !== 1'b0) bail("BUSY idle");
      @(posedge CLK);
      PC_IN <= pc;
      OPC_CLASS <= '{m, m inside {CEAU_AM_IDX_NOOFS, CEAU_AM_IDX_SHORT,
                     CEAU_AM_IDX_LONG}, rmw_v, op};
      START <= 1'b1;
      for (i = 0; i < 50 && BUSY !== 1'b1; i++)
         @(negedge CLK);
      if (BUSY !== 1'b1) bail("BUSY start");
      @(posedge CLK);
      START <= 1'b0;
      for (i = 0; i < 200 && DONE !== 1'b1; i++)
         @(negedge CLK);
      if (DONE !== 1'b1) bail("DONE");
      chk("next_pc", RESULT.next_pc, pc + 16'(n));
   endtask

   task t_inherent;
      go(16'h0100, CEAU_AM_INHERENT, CEAU_OP_CLR_MASK, 32'h9a, 1);
      chk("has_ea", 16'(RESULT.has_ea), 16'h0000);
      chk("irq_mask", 16'(IRQ_MASK), 16'h0000);
      go(16'h0101, CEAU_AM_INHERENT, CEAU_OP_SET_MASK, 32'h9b, 1);
      chk("irq_mask", 16'(IRQ_MASK), 16'h0003);
      go(16'h0102, CEAU_AM_INHERENT, CEAU_OP_HALT, 32'h8e, 1);
      go(16'h0103, CEAU_AM_INHERENT, CEAU_OP_WAIT, 32'h8f, 1);
      @(posedge CLK);
      chk("halt_req", 16'(halt_cnt), 16'h0001);
      chk("wait_req", 16'(wait_cnt), 16'h0001);
      $display("test inherent done");
   endtask

   task t_direct;
      go(16'h0110, CEAU_AM_IMMEDIATE, CEAU_OP_NONE, 32'ha655, 2);
      chk("operand", 16'(RESULT.operand), 16'h0055);
      chk("is_immediate", 16'(RESULT.is_immediate), 16'h0001);
      go(16'h0120, CEAU_AM_DIR_SHORT, CEAU_OP_NONE, 32'hb610, 2);
      chk("ea", RESULT.ea, 16'h0010);
      go(16'h0130, CEAU_AM_DIR_LONG, CEAU_OP_NONE, 32'hc61234, 3);
      chk("ea", RESULT.ea, 16'h1234);
      chk("opcode", 16'(OPCODE), 16'h00c6);
      go(16'h0300, CEAU_AM_REL_DIRECT, CEAU_OP_NONE, 32'h27f0, 2);
      chk("ea", RESULT.ea, 16'h02f2);
      chk("is_relative", 16'(RESULT.is_relative), 16'h0001);
      go(16'h0340, CEAU_AM_BIT_DIRECT, CEAU_OP_NONE, 32'h1a20, 2);
      chk("ea", RESULT.ea, 16'h0020);
      chk("has_ea", 16'(RESULT.has_ea), 16'h0001);
      $display("test direct done");
   endtask

   task t_indexed;
      LAT <= 2'h2;
      go(16'h0140, CEAU_AM_IDX_NOOFS, CEAU_OP_NONE, 32'hf6, 1);
      chk("ea", RESULT.ea, 16'h00f0);
      go(16'h0150, CEAU_AM_IDX_NOOFS, CEAU_OP_NONE, 32'h90f6, 2);
      chk("ea", RESULT.ea, 16'h00ff);
      chk("second_index", 16'(RESULT.second_index), 16'h0001);
      go(16'h0160, CEAU_AM_IDX_SHORT, CEAU_OP_NONE, 32'h90e6ff, 3);
      chk("ea", RESULT.ea, 16'h01fe);
      go(16'h0170, CEAU_AM_IDX_LONG, CEAU_OP_NONE, 32'hd61234, 3);
      chk("ea", RESULT.ea, 16'h1324);
      $display("test indexed done");
   endtask

   // Pointer bytes sit in page zero: word 8090 at 40, byte ff at 42
   task t_indirect;
      mem_u.mem[16'h0040] = 8'h80;
      mem_u.mem[16'h0041] = 8'h90;
      mem_u.mem[16'h0042] = 8'hff;
      go(16'h0200, CEAU_AM_DIR_SHORT, CEAU_OP_NONE, 32'h92b640, 3);
      chk("ea", RESULT.ea, 16'h0080);
      go(16'h0210, CEAU_AM_DIR_LONG, CEAU_OP_NONE, 32'h92c640, 3);
      chk("ea", RESULT.ea, 16'h8090);
      chk("opcode", 16'(OPCODE), 16'h00c6);
      chk("indirect", 16'(RESULT.indirect), 16'h0001);
      go(16'h0220, CEAU_AM_IDX_SHORT, CEAU_OP_NONE, 32'h92e640, 3);
      chk("ea", RESULT.ea, 16'h0170);
      go(16'h0230, CEAU_AM_IDX_SHORT, CEAU_OP_NONE, 32'h91e640, 3);
      chk("ea", RESULT.ea, 16'h017f);
      go(16'h0240, CEAU_AM_IDX_LONG, CEAU_OP_NONE, 32'h92d640, 3);
      chk("ea", RESULT.ea, 16'h8180);
      go(16'h0250, CEAU_AM_IDX_SHORT, CEAU_OP_NONE, 32'h91e642, 3);
      chk("ea", RESULT.ea, 16'h01fe);
      $display("test indirect done");
   endtask

   task t_rmw;
      LAT <= 2'h0;
      rmw_v = 1'b1;
      go(16'h0310, CEAU_AM_DIR_LONG, CEAU_OP_NONE, 32'hc61234, 3);
      chk("illegal", 16'(RESULT.illegal), 16'h0001);
      go(16'h0320, CEAU_AM_DIR_SHORT, CEAU_OP_NONE, 32'hb610, 2);
      chk("illegal", 16'(RESULT.illegal), 16'h0000);
      rmw_v = 1'b0;
      $display("test rmw done");
   endtask

   // Clock enable dropped during the opcode fetch: nothing may move
   task t_freeze;
      int i;
      mem_u.mem[16'h0330] = 8'hc6;
      mem_u.mem[16'h0331] = 8'h56;
      mem_u.mem[16'h0332] = 8'h78;
      for (i = 0; i < 50 && BUSY !== 1'b0; i++)
         @(negedge CLK);
      if (BUSY !== 1'b0) bail("BUSY idle");
      @(posedge CLK);
      PC_IN <= 16'h0330;
      OPC_CLASS <= '{CEAU_AM_DIR_LONG, 1'b0, 1'b0, CEAU_OP_NONE};
      START <= 1'b1;
      @(posedge CLK);
      START <= 1'b0;
      CE <= 1'b0;
      repeat (6) @(negedge CLK);
      chk("frozen_busy", 16'(BUSY), 16'h0001);
      chk("frozen_addr", MEM_REQ.addr, 16'h0330);
      chk("frozen_opvalid", 16'(OPCODE_VALID), 16'h0000);
      chk("frozen_ea", RESULT.ea, 16'h0010);
      @(posedge CLK);
      CE <= 1'b1;
      for (i = 0; i < 200 && DONE !== 1'b1; i++)
         @(negedge CLK);
      if (DONE !== 1'b1) bail("DONE");
      chk("ea", RESULT.ea, 16'h5678);
      chk("next_pc", RESULT.next_pc, 16'h0333);
      $display("test freeze done");
   endtask

   initial begin
      repeat (2) @(posedge CLK);
      chk("irq_mask", 16'(IRQ_MASK), 16'h0003);
      NRST <= 1'b1;
      t_inherent;
      t_direct;
      t_indexed;
      t_indirect;
      t_rmw;
      t_freeze;
      stop_test;
   end
endmodule // cpu_effective_address_unit_tb
